// *** cfg_command_block.sv ***
/*
  Configuration command register with read-only class code and revision,
  plus the gating of system-error drive, initiator commands and target claims.
  Assumes config accesses are single-cycle requests on the PCI clock.
*/
// Behaviour
// - System-error pin is driven only while its drive enable bit is set.
// - Palette snoop bit turns on special handling of VGA palette accesses.
// - Memory Write and Invalidate used only while permit bit set; else plain write.
// - No initiator transactions start while bus-master enable is clear.
// - Memory decode enable gates claims of both 16MByte windows and VGA memory.
// - VGA memory window follows the graphics misc memory-map field and enables.
// - I/O decode enable gates claims of VGA ports and their aliases.
// - Class code is three bytes: base class, sub-class, programming interface.
// - Class code reads as a VGA-compatible display controller.
// - Read-only 8-bit revision identifier chosen by the vendor.
`timescale 1ns/1ps
`default_nettype none
module cfg_command_block
  import cfg_hdr_pkg::*;
#(
  parameter logic [7:0] REVISION = REVISION_DEFAULT
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire cfg_req_type cfg_i,
  output logic cfg_ack_o,
  output logic [31:0] cfg_rdata_o,
  input wire logic serr_event_i,
  output logic serr_n_o,
  output logic serr_oe_n_o,
  input wire logic mst_req_i,
  input wire logic mst_want_inval_i,
  output logic mst_start_o,
  output logic [3:0] mst_cmd_o,
  input wire bus_access_type acc_i,
  input wire logic [7:0] bar0_base_i,
  input wire logic [7:0] bar1_base_i,
  input wire logic [1:0] vga_graphics_misc_reg_i,
  input wire logic vga_enable_i,
  output logic mem_claim_o,
  output logic io_claim_o,
  output logic palette_snoop_o,
  output logic palette_hit_o
);

  logic [15:0] pci_command_reg;
  logic [15:0] pci_command_next;
  logic cfg_ack_reg;
  logic [31:0] cfg_rdata_reg;
  logic serr_drive_reg;
  logic mst_start_reg;
  logic [3:0] mst_cmd_reg;
  claim_type claim_reg;
  claim_type claim_next;

  wire system_error_drive_on = pci_command_reg[CMD_SERR_BIT];
  wire palette_snoop_on = pci_command_reg[CMD_PAL_SNOOP_BIT];
  wire cache_line_write_permit = pci_command_reg[CMD_WR_INVAL_BIT];
  wire bus_master_on = pci_command_reg[CMD_BUS_MASTER_BIT];
  wire mem_decode_on = pci_command_reg[CMD_MEM_DECODE_BIT];
  wire io_decode_on = pci_command_reg[CMD_IO_DECODE_BIT];

  wire cmd_sel = cfg_i.valid && (cfg_i.dword == CMD_DWORD_IDX);
  wire id_sel = cfg_i.valid && (cfg_i.dword == ID_DWORD_IDX);
  wire cmd_wr = cmd_sel && cfg_i.write;
  wire [15:0] lane_mask = {{8{cfg_i.be[1]}}, {8{cfg_i.be[0]}}};
  wire [15:0] wr_mask = lane_mask & CMD_WRITE_MASK;

  // Reserved bits never take a written value, so they stay zero
  assign pci_command_next = cmd_wr ?
    ((pci_command_reg & ~wr_mask) | (cfg_i.wdata[15:0] & wr_mask)) :
    pci_command_reg;

  // Status half of dword 1 belongs elsewhere and reads zero here
  wire [31:0] cmd_dword = {16'h0000, pci_command_reg};
  wire [31:0] id_dword = {FUNCTION_CLASS_VALUE, REVISION};
  wire [31:0] rdata_next = cmd_sel ? cmd_dword : (id_sel ? id_dword : 32'h0000_0000);

  wire serr_drive_next = serr_event_i && system_error_drive_on;
  wire mst_start_next = mst_req_i && bus_master_on;
  wire [3:0] mst_cmd_next = (mst_want_inval_i && cache_line_write_permit) ?
    BUS_CMD_MEM_WRITE_INVAL : BUS_CMD_MEM_WRITE;

  target_claim_decode u_decode (
    .acc_i(acc_i),
    .bar0_base_i(bar0_base_i),
    .bar1_base_i(bar1_base_i),
    .vga_mem_map_i(vga_graphics_misc_reg_i),
    .vga_enable_i(vga_enable_i),
    .mem_decode_on_i(mem_decode_on),
    .io_decode_on_i(io_decode_on),
    .pal_snoop_on_i(palette_snoop_on),
    .claim_o(claim_next)
  );

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pci_command_reg <= CMD_RESET;
    end else begin
      pci_command_reg <= pci_command_next;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_ack_reg <= 1'b0;
      cfg_rdata_reg <= 32'h0000_0000;
    end else begin
      cfg_ack_reg <= cfg_i.valid;
      cfg_rdata_reg <= (cfg_i.valid && !cfg_i.write) ? rdata_next : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      serr_drive_reg <= 1'b0;
      mst_start_reg <= 1'b0;
      mst_cmd_reg <= BUS_CMD_MEM_WRITE;
      claim_reg <= '0;
    end else begin
      serr_drive_reg <= serr_drive_next;
      mst_start_reg <= mst_start_next;
      mst_cmd_reg <= mst_cmd_next;
      claim_reg <= claim_next;
    end
  end

  // Open-drain: pin only ever pulled low, enable active low while driving
  assign serr_n_o = 1'b0;
  assign serr_oe_n_o = !serr_drive_reg;
  assign cfg_ack_o = cfg_ack_reg;
  assign cfg_rdata_o = cfg_rdata_reg;
  assign mst_start_o = mst_start_reg;
  assign mst_cmd_o = mst_cmd_reg;
  assign mem_claim_o = claim_reg.mem_claim;
  assign io_claim_o = claim_reg.io_claim;
  assign palette_hit_o = claim_reg.palette_hit;
  assign palette_snoop_o = palette_snoop_on;

endmodule
`default_nettype wire

// *** cfg_hdr_pkg.sv ***
/*
  Package for the configuration-header command, class-code and revision block:
  dword indices, field positions, write masks, reset values and carrier structs.
  Assumes configuration accesses arrive one dword at a time with byte enables.
*/
package cfg_hdr_pkg;

  // Configuration dword indices (byte offset / 4)
  localparam logic [5:0] CMD_DWORD_IDX = 6'h01;
  localparam logic [5:0] ID_DWORD_IDX = 6'h02;
  // Byte offsets inside the header
  localparam logic [7:0] PCI_COMMAND_OFS = 8'h04;
  localparam logic [7:0] REVISION_IDENTIFIER_OFS = 8'h08;
  localparam logic [7:0] FUNCTION_CLASS_OFS = 8'h09;

  // Command register fields
  localparam int CMD_IO_DECODE_BIT = 0;
  localparam int CMD_MEM_DECODE_BIT = 1;
  localparam int CMD_BUS_MASTER_BIT = 2;
  localparam int CMD_WR_INVAL_BIT = 4;
  localparam int CMD_PAL_SNOOP_BIT = 5;
  localparam int CMD_SERR_BIT = 8;
  localparam logic [15:0] CMD_WRITE_MASK = 16'h0137;
  localparam logic [15:0] CMD_RESET = 16'h0000;

  // VGA display controller class
  localparam logic [23:0] FUNCTION_CLASS_VALUE = 24'h030000;
  // Arbitrary revision value; each silicon revision overrides it
  localparam logic [7:0] REVISION_DEFAULT = 8'h5a;

  // Initiator bus commands
  localparam logic [3:0] BUS_CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] BUS_CMD_MEM_WRITE_INVAL = 4'hf;

  // VGA I/O windows (10-bit decode, so upper address bits alias)
  localparam logic [9:0] VGA_IO_MONO_LO = 10'h3b0;
  localparam logic [9:0] VGA_IO_MONO_HI = 10'h3bb;
  localparam logic [9:0] VGA_IO_COLOR_LO = 10'h3c0;
  localparam logic [9:0] VGA_IO_COLOR_HI = 10'h3df;
  localparam logic [9:0] VGA_PAL_LO = 10'h3c6;
  localparam logic [9:0] VGA_PAL_HI = 10'h3c9;

  // VGA memory windows, compared on address bits 31:15
  localparam logic [16:0] VGA_MEM_A0000 = 17'h00014;
  localparam logic [16:0] VGA_MEM_B0000 = 17'h00016;
  localparam logic [16:0] VGA_MEM_B8000 = 17'h00017;
  localparam logic [16:0] VGA_MEM_C0000 = 17'h00018;

  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] dword;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_type;

  typedef struct packed {
    logic valid;
    logic io;
    logic [31:0] addr;
  } bus_access_type;

  typedef struct packed {
    logic mem_claim;
    logic io_claim;
    logic palette_hit;
  } claim_type;

endpackage

// *** target_claim_decode.sv ***
/*
  Combinational address decoder for target claims: two 16MByte windows,
  the VGA memory window selected by the memory-map field, and VGA I/O ports.
  Assumes the caller registers the result; the command-register enables come in as inputs and are applied here.
*/
`timescale 1ns/1ps
`default_nettype none
module target_claim_decode
  import cfg_hdr_pkg::*;
(
  input wire bus_access_type acc_i,
  input wire logic [7:0] bar0_base_i,
  input wire logic [7:0] bar1_base_i,
  input wire logic [1:0] vga_mem_map_i,
  input wire logic vga_enable_i,
  input wire logic mem_decode_on_i,
  input wire logic io_decode_on_i,
  input wire logic pal_snoop_on_i,
  output claim_type claim_o
);

  wire [16:0] page = acc_i.addr[31:15];
  wire [9:0] port = acc_i.addr[9:0];
  wire bar_hit = (acc_i.addr[31:24] == bar0_base_i) || (acc_i.addr[31:24] == bar1_base_i);
  wire vga_lo_a = (page >= VGA_MEM_A0000) && (page < VGA_MEM_B0000);
  wire vga_b0 = (page == VGA_MEM_B0000);
  wire vga_b8 = (page == VGA_MEM_B8000);
  wire vga_ab = (page >= VGA_MEM_A0000) && (page < VGA_MEM_C0000);
  logic vga_mem_hit;
  always_comb begin
    case (vga_mem_map_i)
      2'b00: vga_mem_hit = vga_ab;
      2'b01: vga_mem_hit = vga_lo_a;
      2'b10: vga_mem_hit = vga_b0;
      2'b11: vga_mem_hit = vga_b8;
      default: vga_mem_hit = 1'b0;
    endcase
  end
  wire io_hit = ((port >= VGA_IO_MONO_LO) && (port <= VGA_IO_MONO_HI)) ||
                ((port >= VGA_IO_COLOR_LO) && (port <= VGA_IO_COLOR_HI));
  wire pal_port = (port >= VGA_PAL_LO) && (port <= VGA_PAL_HI);

  assign claim_o.mem_claim = acc_i.valid && !acc_i.io && mem_decode_on_i &&
                             (bar_hit || (vga_enable_i && vga_mem_hit));
  assign claim_o.io_claim = acc_i.valid && acc_i.io && io_decode_on_i && io_hit;
  assign claim_o.palette_hit = acc_i.valid && acc_i.io && io_decode_on_i &&
                               pal_snoop_on_i && pal_port;

endmodule
`default_nettype wire

// *** cfg_command_block_monitor.sv ***
/* Assertions on the ports of cfg_command_block.
   Assumes one clock domain and the bind below. */
`timescale 1ns/1ps
`default_nettype none
module cfg_command_monitor
  import cfg_hdr_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire cfg_req_type cfg_i,
  input wire logic cfg_ack_o,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic serr_event_i,
  input wire logic serr_oe_n_o,
  input wire logic mst_req_i,
  input wire logic mst_want_inval_i,
  input wire logic mst_start_o,
  input wire logic [3:0] mst_cmd_o,
  input wire bus_access_type acc_i,
  input wire logic mem_claim_o,
  input wire logic io_claim_o,
  input wire logic palette_hit_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire logic [9:0] pa = acc_i.addr[9:0];
  wire logic io_acc = acc_i.valid & acc_i.io;
  wire logic io_vga = io_acc & ((pa >= VGA_IO_MONO_LO & pa <= VGA_IO_MONO_HI) |
    (pa >= VGA_IO_COLOR_LO & pa <= VGA_IO_COLOR_HI));
  wire logic pal = io_acc & pa >= VGA_PAL_LO & pa <= VGA_PAL_HI;
  wire logic rd = cfg_i.valid & !cfg_i.write;
  // Shadow of the command register rebuilt from the writes seen on the port,
  // so every gate below is checked against the enable bit, not just the request
  logic [15:0] cmd_sh;
  wire logic [15:0] sh_mask = {{8{cfg_i.be[1]}}, {8{cfg_i.be[0]}}} & CMD_WRITE_MASK;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_sh <= CMD_RESET;
    end else if (cfg_i.valid && cfg_i.write && cfg_i.dword == CMD_DWORD_IDX) begin
      cmd_sh <= (cmd_sh & ~sh_mask) | (cfg_i.wdata[15:0] & sh_mask);
    end
  end
  serr_gated_a: assert property (!serr_oe_n_o == $past(serr_event_i && cmd_sh[CMD_SERR_BIT]))
    else $error("serr drive does not follow event and enable");
  pal_hit_a: assert property (palette_hit_o ==
    $past(pal && cmd_sh[CMD_IO_DECODE_BIT] && cmd_sh[CMD_PAL_SNOOP_BIT]))
    else $error("palette hit does not follow port and snoop bit");
  inval_cmd_a: assert property (mst_cmd_o ==
    ($past(mst_want_inval_i && cmd_sh[CMD_WR_INVAL_BIT]) ? BUS_CMD_MEM_WRITE_INVAL :
    BUS_CMD_MEM_WRITE)) else $error("bad cmd");
  start_req_a: assert property (mst_start_o ==
    $past(mst_req_i && cmd_sh[CMD_BUS_MASTER_BIT])) else $error("start does not follow enable");
  mem_claim_a: assert property (mem_claim_o |->
    $past(acc_i.valid && !acc_i.io && cmd_sh[CMD_MEM_DECODE_BIT]))
    else $error("mem claim without enabled mem access");
  io_claim_a: assert property (io_claim_o == $past(io_vga && cmd_sh[CMD_IO_DECODE_BIT]))
    else $error("io claim does not follow vga ports and enable");
  class_read_a: assert property (rd && cfg_i.dword == ID_DWORD_IDX |=>
    cfg_ack_o && cfg_rdata_o[31:8] == FUNCTION_CLASS_VALUE) else $error("class code");
  rsvd_zero_a: assert property (rd && cfg_i.dword == CMD_DWORD_IDX |=>
    cfg_ack_o && (cfg_rdata_o & ~{16'h0, CMD_WRITE_MASK}) == 32'h0 &&
    cfg_rdata_o[15:0] == $past(cmd_sh)) else $error("rsvd");
  cover property (mst_cmd_o == BUS_CMD_MEM_WRITE_INVAL);
  cover property (palette_hit_o);
  cover property (!serr_oe_n_o);
endmodule
bind cfg_command_block cfg_command_monitor mon (.clk_i, .resetn_i, .cfg_i, .cfg_ack_o,
  .cfg_rdata_o, .serr_event_i, .serr_oe_n_o, .mst_req_i, .mst_want_inval_i, .mst_start_o,
  .mst_cmd_o, .acc_i, .mem_claim_o, .io_claim_o, .palette_hit_o);
`default_nettype wire

// *** cfg_host_model.sv ***
/* Host bridge model issuing configuration accesses.
   Assumes the block acks one cycle after each request. */
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model
  import cfg_hdr_pkg::*;
(
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] rdata_i,
  output cfg_req_type cfg_o,
  output logic [7:0] bar0_o,
  output logic [7:0] bar1_o
);
  // Bases are fixed before any enable bit is written
  initial begin
    cfg_o = '0;
    bar0_o = 8'h40;
    bar1_o = 8'h50;
  end
  task xfer(input logic w, input logic [5:0] d, input logic [3:0] be,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    #1 cfg_o = '{1'b1, w, d, be, wd};
    @(posedge clk_i);
    #1 rd = (ack_i === 1'b1) ? rdata_i : 'x;
    // Released fields show inverted data so stale values cannot pass
    cfg_o = '{1'b0, ~w, ~d, ~be, ~wd};
  endtask
endmodule
`default_nettype wire

// *** test_cfg_command_block.sv ***
/* Self-checking bench for cfg_command_block.
   Assumes the host model drives the config port. */
`timescale 1ns/1ps
`default_nettype none
module test_cfg_command_block;
  import cfg_hdr_pkg::*;
  logic clk_i = 0;
  logic resetn_i = 0;
  logic ev = 0, rq = 0, wi = 0, ven = 1, ack, sn, soe, mst, mem, io, snp, hit;
  logic [1:0] misc = 2'h1;
  logic [3:0] cmd;
  logic [7:0] b0, b1;
  logic [31:0] rdata, rd;
  cfg_req_type cfg;
  bus_access_type acc = '0;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  always #5 clk_i = ~clk_i;
  cfg_command_block DUT (.clk_i, .resetn_i, .cfg_i(cfg), .cfg_ack_o(ack),
    .cfg_rdata_o(rdata), .serr_event_i(ev), .serr_n_o(sn), .serr_oe_n_o(soe),
    .mst_req_i(rq), .mst_want_inval_i(wi), .mst_start_o(mst), .mst_cmd_o(cmd),
    .acc_i(acc), .bar0_base_i(b0), .bar1_base_i(b1), .vga_graphics_misc_reg_i(misc),
    .vga_enable_i(ven), .mem_claim_o(mem), .io_claim_o(io), .palette_snoop_o(snp),
    .palette_hit_o(hit));
  cfg_host_model host (.clk_i, .cfg_o(cfg), .ack_i(ack), .rdata_i(rdata),
    .bar0_o(b0), .bar1_o(b1));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Expected order: drive enable, start, command, mem, io, palette hit
  task step(input logic e, r, w, i, input logic [31:0] a, input logic [8:0] exp);
    @(posedge clk_i);
    #1 {ev, rq, wi} = {e, r, w};
    acc = '{1'b1, i, a};
    @(posedge clk_i);
    #1 chk({23'h0, soe, mst, cmd, mem, io, hit}, {23'h0, exp});
    {ev, rq, wi} = 3'h0;
    acc = '{1'b0, ~i, ~a};
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 1000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    #1 resetn_i = 1;
    host.xfer(0, 1, 4'hf, 0, rd);
    chk(rd, 32'h0);
    host.xfer(1, 2, 4'hf, '1, rd);
    host.xfer(0, 2, 4'hf, 0, rd);
    chk(rd, {FUNCTION_CLASS_VALUE, REVISION_DEFAULT});
    step(1, 1, 1, 1, 32'h3c8, 9'h138);
    step(0, 0, 0, 0, 32'h40000000, 9'h138);
    host.xfer(1, 1, 4'h3, '1, rd);
    host.xfer(0, 1, 4'hf, 0, rd);
    chk(rd, 32'h0137);
    step(1, 1, 1, 1, 32'h13c8, 9'h0fb);
    step(0, 0, 0, 1, 32'h3bc, 9'h138);
    step(0, 0, 0, 0, 32'h50123456, 9'h13c);
    step(0, 0, 0, 0, 32'h000a8000, 9'h13c);
    step(0, 0, 0, 0, 32'h000b0000, 9'h138);
    misc = 2'h0;
    step(0, 0, 0, 0, 32'h000b8000, 9'h13c);
    misc = 2'h2;
    step(0, 0, 0, 0, 32'h000b0000, 9'h13c);
    misc = 2'h3;
    step(0, 0, 0, 0, 32'h000b0000, 9'h138);
    step(0, 0, 0, 0, 32'h000b8000, 9'h13c);
    ven = 0;
    step(0, 0, 0, 0, 32'h000b8000, 9'h138);
    chk({31'h0, snp}, 32'h1);
    chk({31'h0, sn}, 32'h0);
    host.xfer(1, 1, 4'h1, 32'h3, rd);
    host.xfer(0, 1, 4'hf, 0, rd);
    chk(rd, 32'h0103);
    step(1, 1, 1, 1, 32'h3c8, 9'h03a);
    chk({31'h0, snp}, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
